/* bmu_pkg.sv */
// Register map, field positions, reset values and states of the bus master unit
package bmu_pkg;

    // Register offsets on the plain register port
    localparam logic [15:0] BMU_EN_OFS  = 16'h4340;  // master_enable
    localparam logic [15:0] BMU_CTL_OFS = 16'h4342;  // master_control_status
    localparam logic [15:0] BMU_DAT_OFS = 16'h4344;  // master_data_and_ack
    localparam logic [15:0] BMU_IEN_OFS = 16'h4346;  // master_interrupt_enable

    // Field positions in master_enable
    localparam int BMU_EN_ON_BIT     = 0;   // master_on
    // Field positions in master_control_status
    localparam int BMU_CTL_START_BIT = 0;   // start_request
    localparam int BMU_CTL_STOP_BIT  = 1;   // stop_request
    localparam int BMU_CTL_FILT_BIT  = 4;   // input_filter_on
    localparam int BMU_CTL_TXACT_BIT = 8;   // tx_active_flag
    localparam int BMU_CTL_RXACT_BIT = 9;   // rx_active_flag
    // Field positions in master_data_and_ack
    localparam int BMU_DAT_BYTE_LSB  = 0;   // byte_field low bit
    localparam int BMU_DAT_BYTE_MSB  = 7;   // byte_field high bit
    localparam int BMU_DAT_ACK_BIT   = 8;   // ack_bit
    localparam int BMU_DAT_TXE_BIT   = 9;   // tx_execute
    localparam int BMU_DAT_RXE_BIT   = 10;  // rx_execute
    localparam int BMU_DAT_RDY_BIT   = 11;  // rx_byte_ready
    // Field positions in master_interrupt_enable
    localparam int BMU_IEN_TX_BIT    = 0;   // tx_empty_irq_enable
    localparam int BMU_IEN_RX_BIT    = 1;   // rx_full_irq_enable

    // Reset values
    localparam logic [15:0] BMU_REG_RST  = 16'h0000;  // All four registers
    localparam logic [15:0] BMU_RD_IDLE  = 16'h0000;  // Read data outside a read
    localparam logic [7:0]  BMU_BYTE_RST = 8'h00;     // byte_field after reset

    // Bit counts of one byte transfer: eight data slots then one response slot
    localparam logic [3:0] BMU_LAST_DATA = 4'h7;
    localparam logic [3:0] BMU_ACK_SLOT  = 4'h8;

    // Bus sequencer states
    typedef enum logic [3:0] {
        BMU_IDLE,       // Waiting for a falling bit clock edge
        BMU_BIT_LOW,    // Serial clock low, data bit set up
        BMU_BIT_HIGH,   // Serial clock released, awaiting sample point
        BMU_RS_LOW,     // Data released ahead of a (repeated) start
        BMU_RS_HIGH,    // Clock released, data about to fall
        BMU_ST_HOLD,    // Start seen on the wires, clock about to fall
        BMU_STOP_LOW,   // Data held low ahead of a stop
        BMU_STOP_HIGH   // Clock released, data about to rise
    } bmu_state_t;

endpackage : bmu_pkg

/* bmu_i2c_master.sv */
// Byte oriented two-wire bus master with registers and a shared interrupt
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// [RL1] Tx-empty and rx-full share one interrupt line
// [RL2] Enabled tx cause fires on shift load
// [RL3] Data write clears tx cause; txe 0 sends nothing
// [RL4] Enabled rx cause fires on byte copy
// [RL5] Data read clears rx-full cause
// [RL6] Causes arise only during their own direction
// [RL7] Software infers cause from its current operation
// [RL8] Reserved bits read zero, written zero
// [RL9] master_on starts and stops the master
// [RL10] rx_active_flag high throughout a reception
// [RL11] tx_active_flag high throughout any transmission
// [RL12] input_filter_on filters pin inputs; slow clock
// [RL13] Stop waits for idle, no pending request
// [RL14] stop_request self-clears, bus becomes free
// [RL15] start_request makes start or repeated start
// [RL16] start_request self-clears, bus becomes busy
// [RL17] rx_byte_ready set on copy, cleared by read
// [RL18] rx_execute receives one byte, clears at D7
// [RL19] tx_execute sends byte, clears on shift load
// [RL20] Slave response stored in ack_bit after send
// [RL21] Preset ack_bit driven after each received byte
// [RL22] Transmit served before receive when both set
// [RL23] Nine clocks per byte, ninth is response
// [RL24] Transmit bits MSB first, change on falling edge
// [RL25] Interrupt level is gated tx OR gated rx
module bmu_i2c_master
    import bmu_pkg::*;
(
    input  wire logic        sys_clk,     // Peripheral clock, 40 MHz
    input  wire logic        rst_n,       // Synchronous reset, active low
    input  wire logic [15:0] reg_addr,    // Register byte address
    input  wire logic [15:0] reg_wdata,   // Register write data
    input  wire logic        reg_wr,      // Write strobe, one cycle
    input  wire logic        reg_rd,      // Read strobe, one cycle
    output logic      [15:0] reg_rdata,   // Read data, cycle after the strobe
    input  wire logic        bit_clk,     // Bit clock from the external timer
    input  wire logic        scl_in,      // serial_clock_pin level seen
    output logic             scl_out,     // serial_clock_pin drive level
    output logic             scl_oe,      // serial_clock_pin drive enable
    input  wire logic        sda_in,      // serial_data_pin level seen
    output logic             sda_out,     // serial_data_pin drive level
    output logic             sda_oe,      // serial_data_pin drive enable
    output logic             irq          // Shared request to interrupt_controller
);

    // Every flip-flop of the block
    typedef struct packed {
        bmu_state_t  st;        // Sequencer state
        logic [2:0]  sy1;       // First sync stage: sda, scl, bit clock
        logic [2:0]  sy2;       // Second sync stage
        logic        bclk_prev; // Bit clock one cycle ago, for edges
        logic [1:0]  h1;        // Filter history one: sda, scl
        logic [1:0]  h2;        // Filter history two
        logic [1:0]  flt;       // Pin levels as the sequencer sees them
        logic        en;        // master_on
        logic        filt;      // input_filter_on
        logic        start_request;      // start_request
        logic        stop_request;       // stop_request
        logic        busy;      // Bus held between start and stop
        logic        tx_act;    // tx_active_flag
        logic        rx_act;    // rx_active_flag
        logic [7:0]  byte_f;    // byte_field
        logic [7:0]  shreg;     // Shift register
        logic        ack;       // ack_bit
        logic        tx_execute;       // tx_execute
        logic        rx_execute;       // rx_execute
        logic        rdy;       // rx_byte_ready, also the rx-full cause
        logic        tx_cause;  // Transmit buffer empty cause
        logic        tie;       // tx_empty_irq_enable
        logic        rie;       // rx_full_irq_enable
        logic        dir_rx;    // Current byte is a reception
        logic [3:0]  cnt;       // Bit slot within the byte
        logic        scl_oe;    // Clock pulled low
        logic        sda_oe;    // Data pulled low
        logic        irq;       // Registered interrupt level
        logic [15:0] rdata;     // Registered read data
    } bmu_regs_t;

    bmu_regs_t q_q;   // Current state
    bmu_regs_t q_d;   // Next state
    logic      rise;  // Bit clock rising edge seen
    logic      fall;  // Bit clock falling edge seen
    logic      tx_set; // Transmit cause raised this cycle
    logic      rx_set; // Receive byte copied this cycle

    // Edges of the synchronised bit clock
    assign rise = q_q.sy2[0] & ~q_q.bclk_prev;
    assign fall = ~q_q.sy2[0] & q_q.bclk_prev;

    // Next-state logic for the whole block
    always_comb begin
        q_d    = q_q;
        tx_set = 1'b0;
        rx_set = 1'b0;
        // Pin inputs and bit clock cross in through two stages
        q_d.sy1       = {sda_in, scl_in, bit_clk};
        q_d.sy2       = q_q.sy1;
        q_d.bclk_prev = q_q.sy2[0];
        // Filter wants three equal samples; needs bit clock at most 1/12 sys_clk
        for (int i = 0; i < 2; i++) begin
            q_d.h1[i] = q_q.sy2[i+1];
            q_d.h2[i] = q_q.h1[i];
            if (!q_q.filt) begin
                q_d.flt[i] = q_q.sy2[i+1];
            end else if (q_q.sy2[i+1] == q_q.h1[i] && q_q.h1[i] == q_q.h2[i]) begin // RL12
                q_d.flt[i] = q_q.h1[i];
            end
        end

        if (!q_q.en) begin
            // Disabled: sequencer parked, both wires released
            q_d.st     = BMU_IDLE; // RL9
            q_d.busy   = 1'b0;
            q_d.tx_act = 1'b0;
            q_d.rx_act = 1'b0;
            q_d.scl_oe = 1'b0;
            q_d.sda_oe = 1'b0;
            q_d.cnt    = 4'h0;
        end else begin
            case (q_q.st)
                BMU_IDLE: begin
                    // New work is chosen only on a falling bit clock edge
                    if (fall) begin
                        if (q_q.busy && q_q.tx_execute) begin
                            // Transmit first when both execute bits stand
                            q_d.shreg    = q_q.byte_f; // RL22
                            q_d.tx_execute      = 1'b0;       // RL19
                            q_d.tx_cause = 1'b1;       // RL2
                            tx_set       = 1'b1;
                            q_d.tx_act   = 1'b1;       // RL11
                            q_d.dir_rx   = 1'b0;
                            q_d.cnt      = 4'h0;
                            q_d.sda_oe   = ~q_q.byte_f[7]; // RL24
                            q_d.st       = BMU_BIT_LOW;
                        end else if (q_q.busy && q_q.rx_execute) begin
                            // Reception: data line left to the slave
                            q_d.rx_act = 1'b1; // RL10
                            q_d.dir_rx = 1'b1;
                            q_d.cnt    = 4'h0;
                            q_d.sda_oe = 1'b0;
                            q_d.st     = BMU_BIT_LOW;
                        end else if (q_q.start_request) begin
                            // Release data first so a repeated start can fall
                            q_d.sda_oe = 1'b0; // RL15
                            q_d.st     = BMU_RS_LOW;
                        end else if (q_q.stop_request && q_q.busy) begin
                            // Reached only with no execute or start pending
                            q_d.sda_oe = 1'b1; // RL13
                            q_d.st     = BMU_STOP_LOW;
                        end else if (q_q.stop_request) begin
                            // Stop on a free bus has nothing to do
                            q_d.stop_request = 1'b0;
                        end
                    end
                end
                BMU_BIT_LOW: begin
                    // Release the clock for the slot's high phase
                    if (rise) begin
                        q_d.scl_oe = 1'b0;
                        q_d.st     = BMU_BIT_HIGH;
                    end
                end
                BMU_BIT_HIGH: begin
                    // A slave stretching the clock holds us here
                    if (fall && q_q.flt[0]) begin
                        q_d.scl_oe = 1'b1;
                        q_d.cnt    = q_q.cnt + 4'h1;
                        q_d.st     = BMU_BIT_LOW;
                        if (q_q.cnt == BMU_ACK_SLOT) begin
                            // Ninth slot over: byte complete
                            if (!q_q.dir_rx) begin
                                q_d.ack = q_q.flt[1]; // RL20
                            end
                            q_d.tx_act = 1'b0; // RL11
                            q_d.rx_act = 1'b0; // RL10
                            q_d.sda_oe = 1'b0;
                            q_d.cnt    = 4'h0;
                            q_d.st     = BMU_IDLE; // RL23
                        end else if (q_q.dir_rx) begin
                            q_d.shreg = {q_q.shreg[6:0], q_q.flt[1]};
                            if (q_q.cnt == 4'h0) begin
                                q_d.rx_execute = 1'b0; // RL18
                            end
                            if (q_q.cnt == BMU_LAST_DATA) begin
                                // Byte complete: copy, flag, send preset response
                                q_d.byte_f = {q_q.shreg[6:0], q_q.flt[1]};
                                q_d.rdy    = 1'b1;     // RL4
                                rx_set     = 1'b1;     // RL17
                                q_d.sda_oe = ~q_q.ack; // RL21
                            end
                        end else begin
                            q_d.shreg = {q_q.shreg[6:0], 1'b0};
                            // Last data bit done: float data for the response
                            if (q_q.cnt == BMU_LAST_DATA) begin
                                q_d.sda_oe = 1'b0; // RL23
                            end else begin
                                q_d.sda_oe = ~q_q.shreg[6]; // RL24
                            end
                        end
                    end
                end
                BMU_RS_LOW: begin
                    // Clock released with data high
                    if (rise) begin
                        q_d.scl_oe = 1'b0;
                        q_d.st     = BMU_RS_HIGH;
                    end
                end
                BMU_RS_HIGH: begin
                    // Data falls while the clock is seen high
                    if (fall && q_q.flt[0] && q_q.flt[1]) begin
                        q_d.sda_oe = 1'b1; // RL15
                        q_d.st     = BMU_ST_HOLD;
                    end
                end
                BMU_ST_HOLD: begin
                    // Start made: pull the clock and own the bus
                    if (rise) begin
                        q_d.scl_oe = 1'b1;
                        q_d.start_request   = 1'b0; // RL16
                        q_d.busy   = 1'b1; // RL16
                        q_d.st     = BMU_IDLE;
                    end
                end
                BMU_STOP_LOW: begin
                    // Clock released with data still low
                    if (rise) begin
                        q_d.scl_oe = 1'b0;
                        q_d.st     = BMU_STOP_HIGH;
                    end
                end
                BMU_STOP_HIGH: begin
                    // Data rises while the clock is seen high
                    if (fall && q_q.flt[0]) begin
                        q_d.sda_oe = 1'b0; // RL13
                        q_d.stop_request    = 1'b0; // RL14
                        q_d.busy   = 1'b0; // RL14
                        q_d.st     = BMU_IDLE;
                    end
                end
                default: begin
                    q_d.st = BMU_IDLE;
                end
            endcase
        end

        // Register writes; a hardware set this cycle beats a clear
        if (reg_wr) begin
            case (reg_addr)
                BMU_EN_OFS: begin
                    q_d.en = reg_wdata[BMU_EN_ON_BIT]; // RL9
                end
                BMU_CTL_OFS: begin
                    q_d.filt = reg_wdata[BMU_CTL_FILT_BIT];  // RL12
                    q_d.stop_request  = reg_wdata[BMU_CTL_STOP_BIT];
                    q_d.start_request = reg_wdata[BMU_CTL_START_BIT];
                end
                BMU_DAT_OFS: begin
                    // A received byte landing now is kept over the write
                    if (!rx_set) begin
                        q_d.byte_f = reg_wdata[BMU_DAT_BYTE_MSB:BMU_DAT_BYTE_LSB];
                    end
                    q_d.ack = reg_wdata[BMU_DAT_ACK_BIT];
                    q_d.tx_execute = reg_wdata[BMU_DAT_TXE_BIT];
                    q_d.rx_execute = reg_wdata[BMU_DAT_RXE_BIT];
                    if (!tx_set) begin
                        q_d.tx_cause = 1'b0; // RL3
                    end
                end
                BMU_IEN_OFS: begin
                    q_d.tie = reg_wdata[BMU_IEN_TX_BIT];
                    q_d.rie = reg_wdata[BMU_IEN_RX_BIT];
                end
                default: begin
                    // Unmapped writes are ignored
                end
            endcase
        end

        // Register reads; reserved and unmapped bits read zero
        q_d.rdata = BMU_RD_IDLE; // RL8
        if (reg_rd) begin
            case (reg_addr)
                BMU_EN_OFS: begin
                    q_d.rdata[BMU_EN_ON_BIT] = q_q.en;
                end
                BMU_CTL_OFS: begin
                    q_d.rdata[BMU_CTL_START_BIT] = q_q.start_request;
                    q_d.rdata[BMU_CTL_STOP_BIT]  = q_q.stop_request;
                    q_d.rdata[BMU_CTL_FILT_BIT]  = q_q.filt;
                    q_d.rdata[BMU_CTL_TXACT_BIT] = q_q.tx_act;
                    q_d.rdata[BMU_CTL_RXACT_BIT] = q_q.rx_act;
                end
                BMU_DAT_OFS: begin
                    q_d.rdata[BMU_DAT_BYTE_MSB:BMU_DAT_BYTE_LSB] = q_q.byte_f;
                    q_d.rdata[BMU_DAT_ACK_BIT] = q_q.ack;
                    q_d.rdata[BMU_DAT_TXE_BIT] = q_q.tx_execute;
                    q_d.rdata[BMU_DAT_RXE_BIT] = q_q.rx_execute;
                    q_d.rdata[BMU_DAT_RDY_BIT] = q_q.rdy;
                    if (!rx_set) begin
                        q_d.rdy = 1'b0; // RL5
                    end
                end
                BMU_IEN_OFS: begin
                    q_d.rdata[BMU_IEN_TX_BIT] = q_q.tie;
                    q_d.rdata[BMU_IEN_RX_BIT] = q_q.rie;
                end
                default: begin
                    // Unmapped reads return zero
                end
            endcase
        end

        // One level for both causes, each behind its own enable
        q_d.irq = (q_d.tx_cause & q_d.tie) | (q_d.rdy & q_d.rie); // RL1 RL25
    end

    // State register; zero is the idle state and every register's reset value
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q_q <= bmu_regs_t'(BMU_REG_RST);
        end else begin
            q_q <= q_d;
        end
    end

    // Outputs straight from flip-flops, drive levels tied low; pins are open drain, low only
    assign reg_rdata = q_q.rdata;
    assign scl_oe    = q_q.scl_oe;
    assign sda_oe    = q_q.sda_oe;
    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;
    assign irq       = q_q.irq;

    // Checks on the sequencer and the register file
    default clocking bmu_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    irq_level_a: assert property (irq == ((q_q.tx_cause & q_q.tie) | (q_q.rdy & q_q.rie))) // RL25
        else $error("interrupt level disagrees with gated causes");
    tx_cause_dir_a: assert property ($rose(q_q.tx_cause) |-> q_q.tx_act && !q_q.dir_rx) // RL6
        else $error("transmit cause raised outside transmission");
    rx_ready_dir_a: assert property ($rose(q_q.rdy) |-> q_q.rx_act && q_q.dir_rx) // RL6
        else $error("receive ready raised outside reception");
    txe_load_a: assert property ($fell(q_q.tx_execute) && !$past(reg_wr) |-> q_q.tx_cause && q_q.tx_act) // RL19
        else $error("tx_execute cleared without a shift load");
    read_clear_a: assert property (reg_rd && reg_addr == BMU_DAT_OFS && !rx_set |=> !q_q.rdy) // RL5
        else $error("data read did not clear receive ready");
    stop_gate_a: assert property (q_q.st == BMU_IDLE && (q_q.tx_execute || q_q.rx_execute || q_q.start_request)
        |=> q_q.st != BMU_STOP_LOW) // RL13
        else $error("stop begun with a request pending");
    stop_free_a: assert property ($fell(q_q.stop_request) && !$past(reg_wr) |-> !q_q.busy) // RL14
        else $error("stop request cleared with bus still busy");
    start_busy_a: assert property ($fell(q_q.start_request) && !$past(reg_wr) |-> q_q.busy && q_q.scl_oe) // RL16
        else $error("start request cleared without owning the bus");
    off_idle_a: assert property (!q_q.en |=> q_q.st == BMU_IDLE && !q_q.scl_oe && !q_q.sda_oe) // RL9
        else $error("disabled master still drives the bus");
    read_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == BMU_RD_IDLE) // RL8
        else $error("read data outside the read slot");

    start_seen_c: cover property ($rose(q_q.busy));
    tx_done_c:    cover property ($fell(q_q.tx_act) ##1 q_q.st == BMU_IDLE);
    rx_ready_c:   cover property ($rose(q_q.rdy) && q_q.rie);
    stop_seen_c:  cover property ($fell(q_q.busy) && q_q.en);

endmodule : bmu_i2c_master
`default_nettype wire

/* bmu_slave_model.sv */
// Behavioural two-wire slave facing the bus master
`timescale 1ns/10ps
`default_nettype none
module bmu_slave_model (
    input  wire logic       scl,       // Clock wire level
    input  wire logic       sda,       // Data wire level
    input  wire logic [7:0] tx_byte,   // Byte returned on reads
    output logic            sda_pull,  // High pulls data low
    output logic      [7:0] got,       // Last byte shifted in
    output logic      [7:0] addr       // Address byte of the frame
);
    int   cnt   = 0;     // Falls seen in this byte
    logic rd    = 1'b0;  // Slave is sending
    logic first = 1'b0;  // Next byte is the address
    logic mack  = 1'b1;  // Master response, 1 ends a read
    initial sda_pull = 1'b0;
    // Start or repeated start restarts the byte count; the clock is looked at
    // a moment later, as both wires may move in one time step at a clock fall
    always @(negedge sda) begin
        #1;
        if (scl) begin
            cnt = -1;
            first = 1'b1;
            rd = 1'b0;
        end
    end
    // Stop frees the data line; same settling delay as the start detector
    always @(posedge sda) begin
        #1;
        if (scl) rd = 1'b0;
    end
    // Sample on the rising clock
    always @(posedge scl) begin
        if (cnt == 8) mack = sda;
        else got = {got[6:0], sda};
    end
    // Change the drive only while clock is low, released line floats high
    always @(negedge scl) begin
        cnt = cnt + 1;
        if (cnt == 9) begin
            cnt = 0;
            if (first) addr = got;
            rd = first ? got[0] : (rd & ~mack);
            first = 1'b0;
        end
        sda_pull = (cnt < 8 && rd) ? ~tx_byte[7-cnt] : (cnt == 8 && !rd);
    end
endmodule // bmu_slave_model
`default_nettype wire

/* bmu_i2c_master_test.sv */
// Self-checking bench for the bus master unit
`timescale 1ns/10ps
`default_nettype none
module bmu_i2c_master_test
    import bmu_pkg::*;
;
    logic        sys_clk   = 1'b0;     // 40 MHz
    logic        rst_n     = 1'b0;     // Synchronous reset
    logic [15:0] reg_addr  = 16'h0000; // Register address
    logic [15:0] reg_wdata = 16'h0000; // Write data
    logic        reg_wr    = 1'b0;     // Write strobe
    logic        reg_rd    = 1'b0;     // Read strobe
    logic        bit_clk   = 1'b0;     // Timer bit clock
    logic [15:0] reg_rdata, rv;        // Read port, last word read
    logic        scl_out, scl_oe, sda_out, sda_oe, irq, sda_pull;
    logic [7:0]  got, addr;            // Seen by the slave
    wire  logic  scl_w, sda_w;         // Pulled-up wires
    int          err_total = 0;
    int          checked   = 0;
    // Open drain: any enabled driver wins over the pull-up
    assign scl_w = ~scl_oe;
    assign sda_w = ~(sda_oe | sda_pull);
    initial forever #12.5 sys_clk = ~sys_clk;
    // Unrelated phase to the system clock
    initial begin
        #37;
        forever #100 bit_clk = ~bit_clk;
    end
    bmu_i2c_master bmu_i2c_master_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bit_clk(bit_clk), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    bmu_slave_model bmu_slave_model_i (.scl(scl_w), .sda(sda_w), .tx_byte(8'h3C),
        .sda_pull(sda_pull), .got(got), .addr(addr));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One-cycle write strobe, then a quiet edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
        @(posedge sys_clk);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] e, input string nm);
        rd(a);
        chk(nm, e, rv);
    endtask
    // Bounded polling of a register field
    task automatic poll(input logic [15:0] a, input logic [15:0] m, input logic [15:0] v);
        int n;
        n = 0;
        rd(a);
        while ((rv & m) !== v && n < 800) begin
            rd(a);
            n++;
        end
        chk("poll", v, rv & m);
    endtask
    task automatic wirq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("irq", 16'h0001, {15'h0000, irq});
    endtask
    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #600000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdc(BMU_EN_OFS, 16'h0000, "en");
        rdc(BMU_CTL_OFS, 16'h0000, "ctl");
        rdc(BMU_DAT_OFS, 16'h0000, "dat");
        rdc(16'h4348, 16'h0000, "unmapped");
        wr(BMU_IEN_OFS, 16'h0001);
        rdc(BMU_IEN_OFS, 16'h0001, "ien");
        wr(BMU_EN_OFS, 16'h0001);
        // Write frame with the input filter off
        wr(BMU_CTL_OFS, 16'h0001);
        poll(BMU_CTL_OFS, 16'h0001, 16'h0000);
        wr(BMU_DAT_OFS, 16'h02A0);
        wirq();
        rdc(BMU_DAT_OFS, 16'h00A0, "txe");
        rdc(BMU_CTL_OFS, 16'h0100, "tx busy");
        wr(BMU_DAT_OFS, 16'h0255);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        poll(BMU_DAT_OFS, 16'h0200, 16'h0000);
        poll(BMU_CTL_OFS, 16'h0100, 16'h0000);
        rdc(BMU_DAT_OFS, 16'h0055, "ack");
        chk("slave byte", 16'h0055, {8'h00, got});
        wr(BMU_DAT_OFS, 16'h00AA);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        repeat (100) @(posedge sys_clk);
        rdc(BMU_CTL_OFS, 16'h0000, "no send");
        // Read frame after a repeated start, filter on, tx and rx set together
        wr(BMU_IEN_OFS, 16'h0002);
        wr(BMU_CTL_OFS, 16'h0011);
        poll(BMU_CTL_OFS, 16'h0001, 16'h0000);
        wr(BMU_DAT_OFS, 16'h06A1);
        poll(BMU_DAT_OFS, 16'h0400, 16'h0000);
        rdc(BMU_CTL_OFS, 16'h0210, "rx busy");
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(BMU_DAT_OFS, 16'h0100);
        wirq();
        rdc(BMU_DAT_OFS, 16'h093C, "rx word");
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        chk("address", 16'h00A1, {8'h00, addr});
        // Stop requested while the response slot may still run
        wr(BMU_CTL_OFS, 16'h0012);
        poll(BMU_CTL_OFS, 16'h0002, 16'h0000);
        rdc(BMU_CTL_OFS, 16'h0010, "idle");
        chk("wires", 16'h0003, {14'h0000, scl_w, sda_w});
        chk("pin levels", 16'h0000, {14'h0000, scl_out, sda_out});
        wr(BMU_EN_OFS, 16'h0000);
        tally_and_finish();
    end
endmodule // bmu_i2c_master_test
`default_nettype wire
